//--- src/mtc_cfg.svh
// Offsets, field positions, reset values and fixed codes for the multichannel TDM config bank.
// Assumes inclusion by bare name from the package and the register bank.
`ifndef MTC_CFG_SVH
`define MTC_CFG_SVH
// Register byte offsets on the Wishbone slave
`define MTC_OFS_GLOBAL_MODE 12'h000
`define MTC_OFS_ROUTE_CMD 12'h004
`define MTC_OFS_MODE_HIGH 12'h008
`define MTC_OFS_MODE_LOW 12'h00c
`define MTC_OFS_DESC_BASE 12'h010
`define MTC_OFS_EVENT_BASE 12'h014
`define MTC_OFS_EVENT_PTR 12'h018
`define MTC_OFS_MAX_RX_LEN 12'h01c
`define MTC_OFS_FRAME_THR 12'h020
`define MTC_OFS_FRAME_CNT 12'h024
`define MTC_OFS_SLOT_PTRS_TX 12'h028
`define MTC_OFS_SLOT_PTRS_RX 12'h02c
`define MTC_OFS_CTRL_STATE 12'h030
`define MTC_OFS_STATUS 12'h034
// Routing RAM windows, first and second variant
`define MTC_RAM_V1_BASE 12'h700
`define MTC_RAM_V1_LAST 12'h7ff
`define MTC_RAM_V2_BASE 12'hc00
`define MTC_RAM_V2_LAST 12'hdff
// Global mode field positions
`define MTC_GM_ENB_BIT 3
`define MTC_GM_ENA_BIT 2
`define MTC_GM_RDM_HI 1
`define MTC_GM_RDM_LO 0
// Low mode word fields
`define MTC_ML_ENT_BIT 4
`define MTC_ML_ENR_BIT 5
`define MTC_ML_MODE_HI 3
`define MTC_MODE_MULTICHAN 4'ha
// Routing command codes
`define MTC_ROUTE_NORMAL 8'h00
`define MTC_ROUTE_SHADOW 8'hf0
// Slot entry fields
`define MTC_SLOT_VALID_BIT 15
`define MTC_SLOT_WRAP_BIT 14
`define MTC_SLOT_CP_HI 13
`define MTC_SLOT_CP_LO 8
`define MTC_CP_LOW_ZEROS 6
// Reset values
`define MTC_RST_ZERO32 32'h0000_0000
`endif

//--- src/mtc_pkg.sv
// Types shared by the multichannel TDM config bank and its slot walker.
// Assumes mtc_cfg.svh is on the include path.
`include "mtc_cfg.svh"
package mtc_pkg;
   // One decoded time-slot entry
   typedef struct packed {
      logic valid;
      logic wrap;
      logic [5:0] chan_ptr;
      logic [7:0] mask;
   } mtc_slot_type;
   // Walker states
   typedef enum logic [1:0] {
      MTC_IDLE,
      MTC_FETCH,
      MTC_RUN
   } mtc_walk_type;
endpackage : mtc_pkg

//--- src/mtc_slot_walk.sv
// Steps through one time-slot table held in routing RAM and decodes each entry.
// Assumes a routing RAM read port with one-cycle latency owned by the register bank.
`timescale 1ns/100ps
`include "mtc_cfg.svh"
module mtc_slot_walk #(
   parameter int AW = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic step_i,
   input wire logic [AW-1:0] start_i,
   input wire logic [15:0] rdata_i,
   output logic [AW-1:0] raddr_o,
   output logic [AW-1:0] cur_o,
   output mtc_pkg::mtc_slot_type slot_o,
   output logic [11:0] chan_addr_o
);
   // Walker state and current entry index
   mtc_pkg::mtc_walk_type state_r;
   logic [AW-1:0] cur_r;
   mtc_pkg::mtc_slot_type slot_r;
   logic [11:0] chan_addr_r;
   logic [AW-1:0] raddr_nxt; // Index the RAM port sees, one cycle ahead of FETCH

   // Next entry index; the RAM answers a cycle late, so it must see the new index early
   always_comb begin
      raddr_nxt = cur_r;
      if (state_r == mtc_pkg::MTC_IDLE) begin
         raddr_nxt = start_i;
      end else if (state_r == mtc_pkg::MTC_RUN && run_i && step_i) begin
         raddr_nxt = slot_r.wrap ? start_i : AW'(cur_r + 1'b1);
      end
   end

   assign raddr_o = raddr_nxt;
   assign cur_o = cur_r;
   assign slot_o = slot_r;
   assign chan_addr_o = chan_addr_r;

   // Walk control: reload start pointer when idle, wrap on last entry
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= mtc_pkg::MTC_IDLE;
         cur_r <= '0;
      end else begin
         case (state_r)
            mtc_pkg::MTC_IDLE: begin
               cur_r <= raddr_nxt;
               if (run_i) begin
                  state_r <= mtc_pkg::MTC_FETCH;
               end
            end
            mtc_pkg::MTC_FETCH: begin
               state_r <= run_i ? mtc_pkg::MTC_RUN : mtc_pkg::MTC_IDLE;
            end
            mtc_pkg::MTC_RUN: begin
               if (!run_i) begin
                  state_r <= mtc_pkg::MTC_IDLE;
               end else if (step_i) begin
                  cur_r <= raddr_nxt;
                  state_r <= mtc_pkg::MTC_FETCH;
               end
            end
            default: begin
               state_r <= mtc_pkg::MTC_IDLE;
            end
         endcase
      end
   end

   // Entry decode, latched when the RAM word arrives
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         slot_r <= '0;
         chan_addr_r <= '0;
      end else if (state_r == mtc_pkg::MTC_FETCH) begin
         slot_r.valid <= rdata_i[`MTC_SLOT_VALID_BIT];
         slot_r.wrap <= rdata_i[`MTC_SLOT_WRAP_BIT];
         slot_r.chan_ptr <= rdata_i[`MTC_SLOT_CP_HI:`MTC_SLOT_CP_LO];
         slot_r.mask <= rdata_i[7:0];
         chan_addr_r <= {rdata_i[`MTC_SLOT_CP_HI:`MTC_SLOT_CP_LO], 6'h00};
      end
   end

   chan_low_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) chan_addr_r[5:0] == 6'h00)
      else $error("channel address low bits not zero");
   wrap_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_r == mtc_pkg::MTC_RUN && run_i && step_i && slot_r.wrap) |=> cur_r == $past(start_i))
      else $error("wrap did not return to table start");
endmodule : mtc_slot_walk

//--- src/mtc_cfg_bank.sv
// Register bank for a multichannel TDM HDLC controller: global mode, routing RAM, mode words.
// Assumes a classic Wishbone master on clk_i; one word per register, zero-wait-free single ack.
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/100ps
`include "mtc_cfg.svh"
// Overview of operation
// - First variant: routing RAM at 700-7FF
// - Second variant: 16-bit entries, 32-bit spacing
// - Value 0x0E enables both ports, 32 entries
// - Command 0x00 normal, 0xF0 shadow areas
// - Protocol field 1010 selects multichannel
// - Base pointers locate descriptor and event tables
// - Valid entries flagged, wrap on last
// - Mask bits select processed slot bits
// - Pointer field gives upper address bits
module mtc_cfg_bank #(
   parameter bit VARIANT_TWO = 1'b0,
   parameter int SLOT_AW = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic port_a_active_o,
   output logic port_b_active_o,
   output logic shadow_rx_o,
   output logic shadow_tx_o,
   output logic multichan_run_o,
   output logic [7:0] slot_mask_o,
   output logic [11:0] chan_addr_o
);
   // Configuration registers
   logic [7:0] tdm_global_mode_r;
   logic [7:0] routing_command_reg_r;
   logic [31:0] serial_channel_mode_high_r;
   logic [31:0] serial_channel_mode_low_r;
   logic [31:0] descriptor_table_base_r;
   logic [31:0] event_table_base_r;
   logic [31:0] event_table_ptr_r;
   logic [15:0] max_rx_buffer_length_r;
   logic [15:0] rx_frame_threshold_r;
   logic [15:0] rx_frame_counter_r;
   logic [31:0] tx_ptrs_r;
   logic [31:0] rx_ptrs_r;
   logic [15:0] ctrl_state_r;
   // Routing RAM: 256 bytes, kept as 128 halfword entries
   logic [15:0] route_ram_r [0:127];
   logic [15:0] ram_rdata_r;
   // Bus handshake and decode helpers
   logic req;
   logic wr;
   logic in_ram;
   logic [6:0] ram_idx;
   logic [6:0] ram_pair; // Odd entry sharing the word with ram_idx
   logic ram_lane_ok;
   logic [31:0] rd_nxt;
   logic [SLOT_AW-1:0] tx_raddr;
   mtc_pkg::mtc_slot_type tx_slot;
   logic [11:0] tx_chan;
   logic run;

   // One request per cycle, answered with ack held low in between
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = req && wb_we_i;

   // Merge a write into a word under byte enables
   function automatic logic [31:0] sel_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : sel_merge

   // Routing RAM window decode per variant
   always_comb begin
      in_ram = 1'b0;
      ram_idx = 7'h00;
      ram_lane_ok = 1'b0;
      if (!VARIANT_TWO) begin
         if (wb_adr_i >= `MTC_RAM_V1_BASE && wb_adr_i <= `MTC_RAM_V1_LAST) begin
            in_ram = 1'b1;
            ram_idx = {wb_adr_i[7:2], 1'b0};
            ram_lane_ok = 1'b1;
         end
      end else begin
         if (wb_adr_i >= `MTC_RAM_V2_BASE && wb_adr_i <= `MTC_RAM_V2_LAST) begin
            in_ram = 1'b1;
            ram_idx = wb_adr_i[8:2];
            ram_lane_ok = 1'b1;
         end
      end
   end

   assign ram_pair = {ram_idx[6:1], 1'b1};

   // Acknowledge every request in the cycle after it appears
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // Global mode and routing command registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tdm_global_mode_r <= 8'h00;
         routing_command_reg_r <= `MTC_ROUTE_NORMAL;
      end else if (wr && wb_sel_i[0]) begin
         if (wb_adr_i == `MTC_OFS_GLOBAL_MODE) begin
            tdm_global_mode_r <= wb_dat_i[7:0];
         end else if (wb_adr_i == `MTC_OFS_ROUTE_CMD) begin
            routing_command_reg_r <= wb_dat_i[7:0];
         end
      end
   end

   // Serial channel mode words
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serial_channel_mode_high_r <= `MTC_RST_ZERO32;
         serial_channel_mode_low_r <= `MTC_RST_ZERO32;
      end else if (wr) begin
         if (wb_adr_i == `MTC_OFS_MODE_HIGH) begin
            serial_channel_mode_high_r <= sel_merge(serial_channel_mode_high_r, wb_dat_i, wb_sel_i);
         end else if (wb_adr_i == `MTC_OFS_MODE_LOW) begin
            serial_channel_mode_low_r <= sel_merge(serial_channel_mode_low_r, wb_dat_i, wb_sel_i);
         end
      end
   end

   // Global multichannel parameters and pointers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         descriptor_table_base_r <= `MTC_RST_ZERO32;
         event_table_base_r <= `MTC_RST_ZERO32;
         event_table_ptr_r <= `MTC_RST_ZERO32;
         max_rx_buffer_length_r <= 16'h0000;
         rx_frame_threshold_r <= 16'h0000;
         rx_frame_counter_r <= 16'h0000;
         tx_ptrs_r <= `MTC_RST_ZERO32;
         rx_ptrs_r <= `MTC_RST_ZERO32;
         ctrl_state_r <= 16'h0000;
      end else if (wr) begin
         if (wb_adr_i == `MTC_OFS_DESC_BASE) begin
            descriptor_table_base_r <= sel_merge(descriptor_table_base_r, wb_dat_i, wb_sel_i);
         end else if (wb_adr_i == `MTC_OFS_EVENT_BASE) begin
            event_table_base_r <= sel_merge(event_table_base_r, wb_dat_i, wb_sel_i);
         end else if (wb_adr_i == `MTC_OFS_EVENT_PTR) begin
            event_table_ptr_r <= sel_merge(event_table_ptr_r, wb_dat_i, wb_sel_i);
         end else if (wb_adr_i == `MTC_OFS_MAX_RX_LEN) begin
            max_rx_buffer_length_r <= 16'(sel_merge({16'h0000, max_rx_buffer_length_r}, wb_dat_i, wb_sel_i));
         end else if (wb_adr_i == `MTC_OFS_FRAME_THR) begin
            rx_frame_threshold_r <= 16'(sel_merge({16'h0000, rx_frame_threshold_r}, wb_dat_i, wb_sel_i));
         end else if (wb_adr_i == `MTC_OFS_FRAME_CNT) begin
            rx_frame_counter_r <= 16'(sel_merge({16'h0000, rx_frame_counter_r}, wb_dat_i, wb_sel_i));
         end else if (wb_adr_i == `MTC_OFS_SLOT_PTRS_TX) begin
            tx_ptrs_r <= sel_merge(tx_ptrs_r, wb_dat_i, wb_sel_i);
         end else if (wb_adr_i == `MTC_OFS_SLOT_PTRS_RX) begin
            rx_ptrs_r <= sel_merge(rx_ptrs_r, wb_dat_i, wb_sel_i);
         end else if (wb_adr_i == `MTC_OFS_CTRL_STATE) begin
            ctrl_state_r <= 16'(sel_merge({16'h0000, ctrl_state_r}, wb_dat_i, wb_sel_i));
         end
      end
   end

   // Routing RAM write; first variant packs two entries per word, second uses low lanes only
   always_ff @(posedge clk_i) begin
      if (wr && in_ram && ram_lane_ok) begin
         if (wb_sel_i[0]) route_ram_r[ram_idx][7:0] <= wb_dat_i[7:0];
         if (wb_sel_i[1]) route_ram_r[ram_idx][15:8] <= wb_dat_i[15:8];
         if (!VARIANT_TWO && wb_sel_i[2]) route_ram_r[ram_pair][7:0] <= wb_dat_i[23:16];
         if (!VARIANT_TWO && wb_sel_i[3]) route_ram_r[ram_pair][15:8] <= wb_dat_i[31:24];
      end
   end

   // Walker read port, one cycle latency
   always_ff @(posedge clk_i) begin
      ram_rdata_r <= route_ram_r[tx_raddr[6:0]];
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (in_ram) begin
         rd_nxt = VARIANT_TWO ? {16'h0000, route_ram_r[ram_idx]} : {route_ram_r[ram_pair], route_ram_r[ram_idx]};
      end else if (wb_adr_i == `MTC_OFS_GLOBAL_MODE) begin
         rd_nxt = {24'h000000, tdm_global_mode_r};
      end else if (wb_adr_i == `MTC_OFS_ROUTE_CMD) begin
         rd_nxt = {24'h000000, routing_command_reg_r};
      end else if (wb_adr_i == `MTC_OFS_MODE_HIGH) begin
         rd_nxt = serial_channel_mode_high_r;
      end else if (wb_adr_i == `MTC_OFS_MODE_LOW) begin
         rd_nxt = serial_channel_mode_low_r;
      end else if (wb_adr_i == `MTC_OFS_DESC_BASE) begin
         rd_nxt = descriptor_table_base_r;
      end else if (wb_adr_i == `MTC_OFS_EVENT_BASE) begin
         rd_nxt = event_table_base_r;
      end else if (wb_adr_i == `MTC_OFS_EVENT_PTR) begin
         rd_nxt = event_table_ptr_r;
      end else if (wb_adr_i == `MTC_OFS_MAX_RX_LEN) begin
         rd_nxt = {16'h0000, max_rx_buffer_length_r};
      end else if (wb_adr_i == `MTC_OFS_FRAME_THR) begin
         rd_nxt = {16'h0000, rx_frame_threshold_r};
      end else if (wb_adr_i == `MTC_OFS_FRAME_CNT) begin
         rd_nxt = {16'h0000, rx_frame_counter_r};
      end else if (wb_adr_i == `MTC_OFS_SLOT_PTRS_TX) begin
         rd_nxt = tx_ptrs_r;
      end else if (wb_adr_i == `MTC_OFS_SLOT_PTRS_RX) begin
         rd_nxt = rx_ptrs_r;
      end else if (wb_adr_i == `MTC_OFS_CTRL_STATE) begin
         rd_nxt = {16'h0000, ctrl_state_r};
      end else if (wb_adr_i == `MTC_OFS_STATUS) begin
         rd_nxt = {8'h00, tx_slot, 5'h00, run, port_b_active_o, port_a_active_o};
      end
   end

   // Read data register, only loaded on a read request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req && !wb_we_i) begin
         wb_dat_o <= rd_nxt;
      end
   end

   // protocol field selects multichannel; enables gate the run
   assign run = serial_channel_mode_low_r[`MTC_ML_MODE_HI -: 4] == `MTC_MODE_MULTICHAN
      && serial_channel_mode_low_r[`MTC_ML_ENT_BIT] && port_a_active_o;

   // Port activity and routing area selection outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_a_active_o <= 1'b0;
         port_b_active_o <= 1'b0;
         shadow_rx_o <= 1'b0;
         shadow_tx_o <= 1'b0;
         multichan_run_o <= 1'b0;
      end else begin
         port_a_active_o <= tdm_global_mode_r[`MTC_GM_ENA_BIT];
         // port b relies on division upper bit
         port_b_active_o <= tdm_global_mode_r[`MTC_GM_ENB_BIT] && tdm_global_mode_r[`MTC_GM_RDM_HI];
         shadow_rx_o <= routing_command_reg_r[7] && routing_command_reg_r[5];
         shadow_tx_o <= routing_command_reg_r[6] && routing_command_reg_r[4];
         multichan_run_o <= run;
      end
   end

   // Transmit table walker over routing RAM
   mtc_slot_walk #(.AW(SLOT_AW)) u_tx_walk (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(run),
      .step_i(1'b1),
      .start_i(SLOT_AW'(tx_ptrs_r[SLOT_AW+15:16])),
      .rdata_i(ram_rdata_r),
      .raddr_o(tx_raddr),
      .cur_o(),
      .slot_o(tx_slot),
      .chan_addr_o(tx_chan)
   );

   // Slot mask only passes valid entries; channel address follows every entry
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         slot_mask_o <= 8'h00;
         chan_addr_o <= 12'h000;
      end else begin
         slot_mask_o <= tx_slot.valid ? tx_slot.mask : 8'h00;
         chan_addr_o <= tx_chan;
      end
   end

   shadow_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && wb_sel_i[0] && wb_adr_i == `MTC_OFS_ROUTE_CMD && wb_dat_i[7:0] == `MTC_ROUTE_SHADOW)
      |=> ##1 (shadow_rx_o && shadow_tx_o)) else $error("shadow not selected");
   both_ports_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (tdm_global_mode_r == 8'h0e) |=> (port_a_active_o && port_b_active_o)) else $error("ports not enabled");
   run_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
      multichan_run_o |-> $past(serial_channel_mode_low_r[3:0]) == 4'ha) else $error("run without mode");
   bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req) |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing wrong");
   mask_valid_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !tx_slot.valid |=> slot_mask_o == 8'h00) else $error("mask passed for invalid entry");
   run_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(multichan_run_o));
   shadow_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(shadow_rx_o));
   ram_write_c: cover property (@(posedge clk_i) disable iff (rst_i) wr && in_ram);
endmodule : mtc_cfg_bank

//--- verif/mtc_host_model.sv
// Host side model: a classic Wishbone master that programs the config bank.
// Assumes the slave acks once per request; read data is taken by the bench monitor.
`timescale 1ns/100ps
module mtc_host_model (
   input wire logic clk_i,
   input wire logic ack_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [11:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o
);
   // Idle bus at time zero
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 12'h000;
      sel_o = 4'h0;
      dat_o = 32'h0000_0000;
   end
   // One classic cycle; no ack count assumed, the bench watchdog ends a hang
   task automatic xfer(input logic we, input logic [11:0] adr, input logic [3:0] sel, input logic [31:0] dat);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= we;
      adr_o <= adr;
      sel_o <= sel;
      dat_o <= dat;
      @(posedge clk_i);
      while (ack_i !== 1'b1) begin
         @(posedge clk_i);
      end
      // Released lines show the inverse so stale values never look valid
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o <= ~we;
      adr_o <= ~adr;
      sel_o <= ~sel;
      dat_o <= ~dat;
   endtask : xfer
endmodule : mtc_host_model

//--- verif/multichannel_tdm_hdlc_init_config_bench.sv
// Self-checking bench for the config bank, first routing RAM variant.
// Assumes mtc_host_model as the only bus master; read results checked from a queue.
`timescale 1ns/100ps
`include "mtc_cfg.svh"
module multichannel_tdm_hdlc_init_config_bench;
   logic clk_i = 1'b0; // 25 MHz
   logic rst_i = 1'b1;
   logic cyc, stb, we, ack;
   logic [11:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat;
   logic pa, pb, srx, stx, run;
   logic [7:0] smask;
   logic [11:0] caddr;
   int failures = 0;
   int checks = 0;
   logic [31:0] exp_q[$], msk_q[$]; // Expected read data and compare masks
   logic [31:0] seed = 32'd83636;
   logic [11:0] ia[11] = '{`MTC_OFS_MODE_HIGH, `MTC_OFS_MODE_LOW, `MTC_OFS_DESC_BASE, `MTC_OFS_EVENT_BASE,
      `MTC_OFS_EVENT_PTR, `MTC_OFS_MAX_RX_LEN, `MTC_OFS_FRAME_THR, `MTC_OFS_FRAME_CNT,
      `MTC_OFS_SLOT_PTRS_TX, `MTC_OFS_SLOT_PTRS_RX, `MTC_OFS_CTRL_STATE};
   logic [31:0] iv[11] = '{32'h0000_0780, 32'h0000_000a, 32'h0001_0000, 32'h0000_f000, 32'h0000_f000,
      32'h0000_003c, 32'h0000_0001, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000, 32'h0000_8000};
   logic [7:0] gm[4] = '{8'h0e, 8'h08, 8'h0a, 8'h04};
   logic [7:0] rc[4] = '{8'h00, 8'hf0, 8'ha0, 8'h50};
   logic [31:0] v;
   bit seen0, seen1;

   always #20 clk_i = ~clk_i;

   mtc_host_model host (.clk_i(clk_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
      .sel_o(sel), .dat_o(wdat));

   mtc_cfg_bank #(.VARIANT_TWO(1'b0), .SLOT_AW(8)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .port_a_active_o(pa), .port_b_active_o(pb), .shadow_rx_o(srx), .shadow_tx_o(stx),
      .multichan_run_o(run), .slot_mask_o(smask), .chan_addr_o(caddr));

   // Pseudo-random source
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // One counted comparison
   task automatic check(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         failures++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : check

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, 4'hf, d);
   endtask : wr

   // Note the expectation first, the monitor takes it at the ack edge
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      host.xfer(1'b0, a, 4'hf, 32'h0000_0000);
   endtask : rd

   // Let a write land and the derived outputs follow
   task automatic settle();
      repeat (2) @(posedge clk_i);
      #1;
   endtask : settle

   // Read monitor
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0) begin
         if (exp_q.size() == 0) begin
            check(1'b0, "read without note");
         end else begin
            check((rdat & msk_q[0]) === (exp_q[0] & msk_q[0]), "read data");
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
         end
      end
   end

   task automatic final_report();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report

   // Watchdog well beyond the expected run
   initial begin
      #(40 * 30000);
      failures++;
      final_report();
   end

   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      check({pa, pb, srx, stx, run, smask, caddr} === 25'h0, "outputs after reset");
      rd(`MTC_OFS_STATUS, 32'h0, 32'h7);
      foreach (ia[i]) begin
         wr(ia[i], iv[i]);
         rd(ia[i], iv[i], 32'hffff_ffff);
      end
      // Storage registers with random data, then a single-lane merge
      for (logic [11:0] a = `MTC_OFS_DESC_BASE; a <= `MTC_OFS_CTRL_STATE; a += 12'h004) begin
         if (a == `MTC_OFS_SLOT_PTRS_TX || a == `MTC_OFS_SLOT_PTRS_RX) continue;
         seed = lfsr(seed);
         wr(a, seed);
         host.xfer(1'b1, a, 4'h2, ~seed);
         // Halfword registers read zero above bit 15
         v = ((a >= `MTC_OFS_MAX_RX_LEN && a <= `MTC_OFS_FRAME_CNT) || a == `MTC_OFS_CTRL_STATE) ? 32'h0000_ffff
            : 32'hffff_ffff;
         rd(a, {seed[31:16], ~seed[15:8], seed[7:0]}, v);
      end
      // Unmapped places read zero, including both sides of the routing window
      foreach (ia[i]) begin
         v = (i == 0) ? 32'h038 : (i == 1) ? 32'h800 : 32'h6fc;
         if (i > 2) break;
         seed = lfsr(seed);
         wr(v[11:0], seed);
         rd(v[11:0], 32'h0, 32'hffff_ffff);
      end
      // routing RAM spans 700 through 7ff
      for (int w = 0; w < 256; w += 60) begin
         seed = lfsr(seed);
         wr(12'h700 + 12'(w & 252), seed);
         rd(12'h700 + 12'(w & 252), seed, 32'hffff_ffff);
      end
      wr(`MTC_RAM_V1_LAST - 12'h003, 32'h1234_abcd);
      rd(`MTC_RAM_V1_LAST - 12'h003, 32'h1234_abcd, 32'hffff_ffff);
      foreach (gm[i]) begin
         wr(`MTC_OFS_GLOBAL_MODE, {24'h0, gm[i]});
         settle();
         check(pa === gm[i][2] && pb === (gm[i][3] & gm[i][1]), "port enables");
         rd(`MTC_OFS_GLOBAL_MODE, {24'h0, gm[i]}, 32'hff);
         rd(`MTC_OFS_STATUS, {30'h0, gm[i][3] & gm[i][1], gm[i][2]}, 32'h3);
      end
      // normal, shadow and split routing selections
      foreach (rc[i]) begin
         wr(`MTC_OFS_ROUTE_CMD, {24'h0, rc[i]});
         settle();
         check(srx === (rc[i][7] & rc[i][5]) && stx === (rc[i][6] & rc[i][4]), "routing select");
         rd(`MTC_OFS_ROUTE_CMD, {24'h0, rc[i]}, 32'hff);
      end
      wr(`MTC_RAM_V1_BASE, {16'hc30f, 16'h85ff});
      wr(`MTC_OFS_GLOBAL_MODE, 32'h0000_000e);
      wr(`MTC_OFS_MODE_LOW, 32'h0000_001b);
      settle();
      check(run === 1'b0, "run with wrong protocol");
      wr(`MTC_OFS_MODE_LOW, 32'h0000_001a);
      settle();
      check(run === 1'b1, "multichannel run");
      rd(`MTC_OFS_STATUS, 32'h7, 32'h7);
      repeat (1000) begin
         @(posedge clk_i);
         #1;
         seen0 |= (smask === 8'hff && caddr === 12'h140);
         seen1 |= (smask === 8'h0f && caddr === 12'h0c0);
      end
      check(seen0 && seen1, "slot walk entries");
      wr(`MTC_OFS_GLOBAL_MODE, 32'h0000_0000);
      settle();
      check(run === 1'b0 && pa === 1'b0, "run without port a");
      final_report();
   end
endmodule : multichannel_tdm_hdlc_init_config_bench
